// file: plsid_bridge.sv
// Bridge end: lock forwarding and subsystem identity register
`timescale 1ns/1ps
`default_nettype none
module plsid_bridge (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        suspend,
   input  wire logic [3:0]  lock_route,
   plsid_if.bridge          bus,
   output logic             multipurpose_terminal_four,
   output logic             card_bus_lock_line_o,
   output logic             card_bus_lock_line_oe_n,
   input  wire logic        card_bus_lock_line_i,
   output logic             posting_enable,
   output logic             ee_req,
   output logic [0:0]       ee_word,
   input  wire logic        ee_ack,
   input  wire logic [15:0] ee_data,
   output logic             load_busy
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [31:0]          ident;
      logic [31:0]          sysctl;
      logic [31:0]          rdata;
      logic                 ack;
      logic                 mem_ack;
      logic                 mem_retry;
      logic                 locked;
      logic [27:0]          region;
      logic                 lock_prev;
      logic                 cb_lock;
      logic                 post_en;
      plsid_pkg::plsid_ld_e ld;
      logic [1:0]           ld_cnt;
      logic                 ee_req;
      logic                 mft4;
      logic                 busy;
   } plsid_br_s;

   plsid_br_s s_q;
   plsid_br_s s_d;
   logic      core_rst;
   logic      lock_in;
   logic      hit;

   // Reset is gated by suspend so a sleeping core keeps its identity
   assign core_rst = rst & ~suspend;
   // Lock only seen when routed; card side lock is never an input
   assign lock_in  = (lock_route == plsid_pkg::ROUTE_LOCK_CODE)
                     & ~bus.lock_n;
   assign hit      = plsid_pkg::plsid_region(bus.mem_addr) == s_q.region;

   // ==========================================================
   // Identity load helper
   // Keeps the other half, so one narrow word lands at a time
   function automatic logic [31:0] put_half(input logic [31:0] word,
                                            input logic        upper,
                                            input logic [15:0] half);
      return upper ? {half, word[15:0]} : {word[31:16], half};
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      s_d           = s_q;
      s_d.ack       = 1'b0;
      s_d.mem_ack   = 1'b0;
      s_d.mem_retry = 1'b0;
      s_d.lock_prev = lock_in;
      s_d.mft4      = lock_in;

      // ==========================================================
      // Configuration space
      if (bus.cfg_req) begin
         s_d.ack = 1'b1;
         // Both functions map the same doubleword
         unique case (bus.cfg_addr)
            plsid_pkg::SUBSYS_ID_OFF: begin
               s_d.rdata = s_q.ident;
               if (bus.cfg_we &&
                   s_q.sysctl[plsid_pkg::SUBSYS_WE_BIT]) begin
                  s_d.ident = bus.cfg_wdata;
               end
            end
            plsid_pkg::SYS_CTRL_OFF: begin
               s_d.rdata = s_q.sysctl;
               if (bus.cfg_we) begin
                  s_d.sysctl = bus.cfg_wdata & plsid_pkg::SYS_CTRL_WMASK;
               end
            end
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end

      // ==========================================================
      // Lock tracking
      // Lock is taken by its own handshake: an access in the same cycle that lock first goes low
      if (!lock_in) begin
         s_d.locked = 1'b0;
      end else if (bus.mem_req && !s_q.locked && !s_q.lock_prev) begin
         s_d.locked = 1'b1;
         s_d.region = plsid_pkg::plsid_region(bus.mem_addr);
      end
      s_d.cb_lock = s_d.locked;
      s_d.post_en = ~s_d.locked;

      // ==========================================================
      // Memory answers
      if (bus.mem_req) begin
         // Other regions pass; locked region refused only in the cycle lock is released
         if (s_q.locked && hit && s_q.lock_prev && !lock_in) begin
            s_d.mem_retry = 1'b1;
         end else begin
            s_d.mem_ack = 1'b1;
         end
      end

      // ==========================================================
      // Identity load from EEPROM
      // One half-word per request; the loaded half beats a config write
      unique case (s_q.ld)
         plsid_pkg::PLSID_LD_IDLE: s_d.ee_req = 1'b0;
         plsid_pkg::PLSID_LD_REQ: begin
            s_d.ee_req = 1'b1;
            s_d.ld     = plsid_pkg::PLSID_LD_WAIT;
         end
         plsid_pkg::PLSID_LD_WAIT: begin
            if (ee_ack) begin
               s_d.ee_req = 1'b0;
               s_d.ident  = put_half(s_d.ident, s_q.ld_cnt[0],
                                     ee_data);
               s_d.ld_cnt = s_q.ld_cnt + 2'h1;
               if (s_q.ld_cnt + 2'h1 == plsid_pkg::EE_WORDS) begin
                  s_d.ld = plsid_pkg::PLSID_LD_IDLE;
               end else begin
                  s_d.ld = plsid_pkg::PLSID_LD_REQ;
               end
            end
         end
         default: begin
            s_d.ee_req = 1'b0;
            s_d.ld     = plsid_pkg::PLSID_LD_IDLE;
         end
      endcase
      s_d.busy = s_d.ld != plsid_pkg::PLSID_LD_IDLE;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk) begin
      if (core_rst) begin
         s_q.ident     <= plsid_pkg::SUBSYS_ID_RESET;
         s_q.sysctl    <= plsid_pkg::SYS_CTRL_RESET;
         s_q.rdata     <= 32'h0000_0000;
         s_q.ack       <= 1'b0;
         s_q.mem_ack   <= 1'b0;
         s_q.mem_retry <= 1'b0;
         s_q.locked    <= 1'b0;
         s_q.region    <= 28'h000_0000;
         s_q.lock_prev <= 1'b0;
         s_q.cb_lock   <= 1'b0;
         s_q.post_en   <= 1'b1;
         s_q.ld        <= plsid_pkg::PLSID_LD_REQ;
         s_q.ld_cnt    <= 2'h0;
         s_q.ee_req    <= 1'b0;
         s_q.mft4      <= 1'b0;
         s_q.busy      <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   assign bus.cfg_rdata              = s_q.rdata;
   assign bus.cfg_ack                = s_q.ack;
   assign bus.mem_ack                = s_q.mem_ack;
   assign bus.mem_retry              = s_q.mem_retry;
   assign multipurpose_terminal_four = s_q.mft4;
   // Open drain, active low card lock
   assign card_bus_lock_line_o       = 1'b0;
   assign card_bus_lock_line_oe_n    = ~s_q.cb_lock;
   assign posting_enable             = s_q.post_en;
   assign ee_req                     = s_q.ee_req;
   assign ee_word                    = s_q.ld_cnt[0];
   assign load_busy                  = s_q.busy;
endmodule
`default_nettype wire

// file: plsid_host.sv
// Host end: configuration writer and lock master
`timescale 1ns/1ps
`default_nettype none
module plsid_host (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   plsid_if.host            bus,
   input  wire logic        cmd_cfg,
   input  wire logic        cmd_we,
   input  wire logic [7:0]  cmd_addr,
   input  wire logic [31:0] cmd_wdata,
   input  wire logic        cmd_lock,
   input  wire logic        cmd_mem,
   input  wire logic [31:0] cmd_mem_addr,
   input  wire logic        cmd_mem_write,
   output logic [31:0]      rsp_data,
   output logic             rsp_done
);
   // ==========================================================
   // State
   typedef struct packed {
      logic        cfg_req;
      logic        cfg_we;
      logic [7:0]  cfg_addr;
      logic [31:0] cfg_wdata;
      logic        lock_n;
      logic        mem_req;
      logic [31:0] mem_addr;
      logic        mem_write;
      logic [31:0] rdata;
      logic        done;
   } plsid_ho_s;

   plsid_ho_s h_q;
   plsid_ho_s h_d;

   always_comb begin
      h_d         = h_q;
      h_d.cfg_req = 1'b0;
      h_d.mem_req = 1'b0;
      h_d.done    = 1'b0;
      // Firmware sets enable, writes identity, then clears enable
      if (cmd_cfg) begin
         h_d.cfg_req   = 1'b1;
         h_d.cfg_we    = cmd_we;
         h_d.cfg_addr  = cmd_addr;
         h_d.cfg_wdata = cmd_wdata;
      end
      // Lock held only downstream; arbiter policy lives outside
      h_d.lock_n = ~cmd_lock;
      if (cmd_mem) begin
         h_d.mem_req   = 1'b1;
         h_d.mem_addr  = cmd_mem_addr;
         h_d.mem_write = cmd_mem_write;
      end
      if (bus.cfg_ack) begin
         h_d.rdata = bus.cfg_rdata;
         h_d.done  = 1'b1;
      end
      if (bus.mem_ack || bus.mem_retry) begin
         h_d.done = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         h_q        <= '0;
         h_q.lock_n <= 1'b1;
      end else begin
         h_q <= h_d;
      end
   end

   assign bus.cfg_req   = h_q.cfg_req;
   assign bus.cfg_we    = h_q.cfg_we;
   assign bus.cfg_func  = 1'b0;
   assign bus.cfg_addr  = h_q.cfg_addr;
   assign bus.cfg_wdata = h_q.cfg_wdata;
   assign bus.lock_n    = h_q.lock_n;
   assign bus.mem_req   = h_q.mem_req;
   assign bus.mem_addr  = h_q.mem_addr;
   assign bus.mem_write = h_q.mem_write;
   assign rsp_data      = h_q.rdata;
   assign rsp_done      = h_q.done;
endmodule
`default_nettype wire

// file: plsid_if.sv
// Interface joining the bridge end and the host end
`timescale 1ns/1ps
`default_nettype none
interface plsid_if;
   // Configuration access from the host
   logic        cfg_req;
   logic        cfg_we;
   logic        cfg_func;
   logic [7:0]  cfg_addr;
   logic [31:0] cfg_wdata;
   logic [31:0] cfg_rdata;
   logic        cfg_ack;
   // Bus lock and memory transaction from the host
   logic        lock_n;
   logic        mem_req;
   logic [31:0] mem_addr;
   logic        mem_write;
   logic        mem_ack;
   logic        mem_retry;
   modport bridge (
      input  cfg_req, cfg_we, cfg_func, cfg_addr, cfg_wdata,
      output cfg_rdata, cfg_ack,
      input  lock_n, mem_req, mem_addr, mem_write,
      output mem_ack, mem_retry
   );
   modport host (
      output cfg_req, cfg_we, cfg_func, cfg_addr, cfg_wdata,
      input  cfg_rdata, cfg_ack,
      output lock_n, mem_req, mem_addr, mem_write,
      input  mem_ack, mem_retry
   );
endinterface
`default_nettype wire

// file: plsid_monitor.sv
// Interface checker for the lock and subsystem id ends
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Checker
module plsid_monitor (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        cfg_req,
   input wire logic        cfg_we,
   input wire logic [7:0]  cfg_addr,
   input wire logic [31:0] cfg_rdata,
   input wire logic        cfg_ack,
   input wire logic        lock_n,
   input wire logic        mem_req,
   input wire logic        mem_ack,
   input wire logic        mem_retry
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   ack_due_a: assert property (cfg_req |=> cfg_ack)
      else $error("config request not acknowledged");
   ack_cause_a: assert property (cfg_ack |-> $past(cfg_req))
      else $error("config acknowledge without request");
   rdata_hold_a: assert property (!cfg_ack |-> $stable(cfg_rdata))
      else $error("read data moved without acknowledge");
   // Only the two mapped doublewords may return data
   unmapped_zero_a: assert property (cfg_req && !cfg_we &&
      cfg_addr != 8'h40 && cfg_addr != 8'h80 |=> cfg_rdata == 32'h0)
      else $error("unmapped read returned data");
   ctrl_mask_a: assert property (cfg_req && !cfg_we &&
      cfg_addr == 8'h80 |=> (cfg_rdata & 32'hffff_ffdf) == 32'h0)
      else $error("control read shows bits beyond enable");
   mem_answer_a: assert property (mem_req |=> mem_ack ^ mem_retry)
      else $error("memory request not answered once");
   mem_cause_a: assert property ((mem_ack || mem_retry) |->
      $past(mem_req))
      else $error("memory answer without request");
   unlocked_ack_a: assert property (mem_req && lock_n &&
      $past(lock_n) |=> mem_ack)
      else $error("unlocked access was retried");
endmodule
`default_nettype wire

// file: plsid_pkg.sv
// Package of shared constants and types for the lock and subsystem id block
package plsid_pkg;
   // ==========================================================
   // Configuration offsets and fields
   localparam logic [7:0]  SUBSYS_ID_OFF       = 8'h40;
   localparam logic [7:0]  SYS_CTRL_OFF        = 8'h80;
   localparam int          SUBSYS_WE_BIT       = 5;
   localparam logic [31:0] SUBSYS_ID_RESET     = 32'h0000_0000;
   localparam logic [31:0] SYS_CTRL_RESET      = 32'h0000_0000;
   localparam logic [31:0] SYS_CTRL_WMASK      = 32'h0000_0020;
   // Multifunction routing code that puts lock on terminal four
   localparam logic [3:0]  ROUTE_LOCK_CODE     = 4'h5;
   // Lock granularity: 16-byte aligned, so compare address bits 31:4
   localparam int          LOCK_GRAIN_LSB      = 4;
   // EEPROM load: words of identity read after a bus reset
   localparam logic [1:0]  EE_WORDS            = 2'h2;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PLSID_LD_IDLE,
      PLSID_LD_REQ,
      PLSID_LD_WAIT
   } plsid_ld_e;
   // Lock region address of a 16-byte block
   function automatic logic [27:0] plsid_region(input logic [31:0] addr);
      return addr[31:LOCK_GRAIN_LSB];
   endfunction
endpackage

// file: tb.sv
// Testbench joining bridge and host ends through the interface
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench
module tb;
   localparam logic [31:0] EE_ID = 32'h5a5a_1234;
   logic        sys_clk, rst, suspend, cmd_cfg, cmd_we, cmd_lock, cmd_mem;
   logic        cmd_mem_write, rsp_done, mtf, cbl_o, cbl_oe_n, post_en;
   logic        ee_req, ee_ack, load_busy, got_retry;
   logic [0:0]  ee_word;
   logic [3:0]  route;
   logic [7:0]  cmd_addr;
   logic [15:0] ee_data;
   logic [31:0] cmd_wdata, cmd_mem_addr, rsp_data;
   int          n_fail, samples_checked;
   plsid_if ifc ();
   plsid_bridge plsid_bridge_inst (.sys_clk(sys_clk), .rst(rst),
      .suspend(suspend), .lock_route(route), .bus(ifc),
      .multipurpose_terminal_four(mtf), .card_bus_lock_line_o(cbl_o),
      .card_bus_lock_line_oe_n(cbl_oe_n),
      .card_bus_lock_line_i(cbl_oe_n ? 1'b1 : cbl_o),
      .posting_enable(post_en), .ee_req(ee_req), .ee_word(ee_word),
      .ee_ack(ee_ack), .ee_data(ee_data), .load_busy(load_busy));
   plsid_host plsid_host_inst (.sys_clk(sys_clk), .rst(rst), .bus(ifc),
      .cmd_cfg(cmd_cfg), .cmd_we(cmd_we), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_lock(cmd_lock), .cmd_mem(cmd_mem),
      .cmd_mem_addr(cmd_mem_addr), .cmd_mem_write(cmd_mem_write),
      .rsp_data(rsp_data), .rsp_done(rsp_done));
   plsid_monitor plsid_monitor_inst (.sys_clk(sys_clk), .rst(rst),
      .cfg_req(ifc.cfg_req), .cfg_we(ifc.cfg_we), .cfg_addr(ifc.cfg_addr),
      .cfg_rdata(ifc.cfg_rdata), .cfg_ack(ifc.cfg_ack),
      .lock_n(ifc.lock_n), .mem_req(ifc.mem_req), .mem_ack(ifc.mem_ack),
      .mem_retry(ifc.mem_retry));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Serial memory stand-in: one ack pulse per held request
   always @(posedge sys_clk) begin
      #1;
      ee_ack = (ee_req === 1'b1) && !ee_ack;
      ee_data = ee_word[0] ? EE_ID[31:16] : EE_ID[15:0];
   end
   // ============================================================
   // Tasks
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   task automatic cfg(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      cmd_cfg = 1'b1;
      cmd_we = w;
      cmd_addr = a;
      cmd_wdata = d;
      tick(1);
      cmd_cfg = 1'b0;
      for (i = 0; i < 20 && rsp_done !== 1'b1; i++) tick(1);
      chkb(rsp_done, 1'b1);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      cfg(1'b0, a, 32'h0);
      chk(rsp_data, e);
   endtask
   task automatic mem(input logic [31:0] a);
      int i;
      cmd_mem = 1'b1;
      cmd_mem_addr = a;
      cmd_mem_write = 1'b1;
      tick(1);
      cmd_mem = 1'b0;
      for (i = 0; i < 20 && !(ifc.mem_ack || ifc.mem_retry); i++) tick(1);
      got_retry = ifc.mem_retry;
      tick(2);
   endtask
   task automatic do_reset();
      int i;
      rst = 1'b1;
      tick(3);
      rst = 1'b0;
      tick(2);
      for (i = 0; i < 50 && load_busy !== 1'b0; i++) tick(1);
   endtask
   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge sys_clk);
      n_fail++;
      report_and_stop();
   end
   // ============================================================
   // Sequence
   initial begin
      {n_fail, samples_checked} = '0;
      {rst, suspend, cmd_cfg, cmd_we, cmd_lock, cmd_mem} = 6'h20;
      {cmd_mem_write, cmd_addr} = '0;
      {cmd_wdata, cmd_mem_addr} = '0;
      route = plsid_pkg::ROUTE_LOCK_CODE;
      do_reset();
      chkb(ifc.lock_n, 1'b1);
      rd_chk(8'h40, EE_ID);
      rd_chk(8'h80, 32'h0);
      cfg(1'b1, 8'h40, 32'h1111_2222);
      rd_chk(8'h40, EE_ID);
      cfg(1'b1, 8'h80, 32'hffff_ffff);
      rd_chk(8'h80, 32'h20);
      cfg(1'b1, 8'h40, 32'h1111_2222);
      rd_chk(8'h40, 32'h1111_2222);
      cfg(1'b1, 8'h80, 32'h0);
      cfg(1'b1, 8'h40, 32'h3333_4444);
      rd_chk(8'h40, 32'h1111_2222);
      rd_chk(8'h44, 32'h0);
      suspend = 1'b1;
      do_reset();
      rd_chk(8'h40, 32'h1111_2222);
      suspend = 1'b0;
      do_reset();
      rd_chk(8'h40, EE_ID);
      // Lock and first access leave the host together
      cmd_lock = 1'b1;
      mem(32'h0000_1000);
      chkb(ifc.lock_n, 1'b0);
      chkb(post_en, 1'b0);
      chkb(cbl_oe_n, 1'b0);
      chkb(mtf, 1'b1);
      mem(32'h0000_2000);
      chkb(got_retry, 1'b0);
      mem(32'h0000_100c);
      chkb(got_retry, 1'b0);
      // Access into the held region in the cycle lock is released must be refused
      cmd_lock = 1'b0;
      mem(32'h0000_1004);
      chkb(got_retry, 1'b1);
      tick(3);
      chkb(post_en, 1'b1);
      chkb(cbl_oe_n, 1'b1);
      route = 4'h0;
      cmd_lock = 1'b1;
      tick(3);
      mem(32'h0000_1000);
      chkb(post_en, 1'b1);
      chkb(mtf, 1'b0);
      cmd_lock = 1'b0;
      tick(3);
      report_and_stop();
   end
endmodule
`default_nettype wire
